// [src/pmps_port.sv]
`timescale 1ns/1ns
// External program memory port with clock-select straps on the two lowest address pins.
module pmps_port #(
    parameter int ADDR_W = pmps_pkg::ADDR_W,
    parameter int DATA_W = pmps_pkg::DATA_W
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic power_down_i,
    input wire logic standby_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic [1:0] strap_o,
    output logic [1:0] clk_sel_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [ADDR_W-1:0] mem_addr_oe_o,
    output logic [1:0] mem_addr_pd_o,
    input wire logic [1:0] mem_addr_low_i,
    output logic [DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    input wire logic [DATA_W-1:0] mem_data_i,
    output logic prog_write_strobe_low_o,
    output logic prog_read_strobe_low_o,
    output logic prog_chip_enable_low_o
);
    typedef struct packed {
        pmps_pkg::pmps_state_t state;
        logic [1:0] cnt;
        logic wr;
        logic in_reset;
        logic [1:0] strap;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rd_valid;
    } pmps_regs_t;

    pmps_regs_t r;
    pmps_regs_t next_r;

    // Strap decode shared by the clock-select output.
    function automatic pmps_pkg::pmps_clk_t pmps_decode(input logic [1:0] s);
        if (s == pmps_pkg::STRAP_24MHZ) begin
            pmps_decode = pmps_pkg::PMPS_CLK_24;
        end else if (s == pmps_pkg::STRAP_48MHZ) begin
            pmps_decode = pmps_pkg::PMPS_CLK_48;
        end else begin
            pmps_decode = pmps_pkg::PMPS_CLK_RSVD;
        end
    endfunction

    // Next-state logic; the strap is caught on the first clean edge after reset falls.
    always_comb begin
        next_r = r;
        next_r.rd_valid = 1'b0;
        next_r.in_reset = 1'b0;
        if (r.in_reset) begin
            next_r.strap = mem_addr_low_i;
        end
        case (r.state)
            pmps_pkg::PMPS_IDLE: begin
                if (req_valid_i && !standby_i && !r.in_reset) begin
                    next_r.state = pmps_pkg::PMPS_SETUP;
                    next_r.addr = req_addr_i;
                    next_r.wdata = req_wdata_i;
                    next_r.wr = req_write_i;
                    next_r.cnt = pmps_pkg::SETUP_CYC - 2'h1;
                end
            end
            pmps_pkg::PMPS_SETUP: begin
                if (r.cnt == 2'h0) begin
                    next_r.state = pmps_pkg::PMPS_STROBE;
                    next_r.cnt = pmps_pkg::STROBE_CYC - 2'h1;
                end else begin
                    next_r.cnt = r.cnt - 2'h1;
                end
            end
            pmps_pkg::PMPS_STROBE: begin
                if (r.cnt == 2'h0) begin
                    next_r.state = pmps_pkg::PMPS_HOLD;
                    next_r.cnt = pmps_pkg::HOLD_CYC - 2'h1;
                    if (!r.wr) begin
                        next_r.rdata = mem_data_i;
                        next_r.rd_valid = 1'b1;
                    end
                end else begin
                    next_r.cnt = r.cnt - 2'h1;
                end
            end
            pmps_pkg::PMPS_HOLD: begin
                if (r.cnt == 2'h0) begin
                    next_r.state = pmps_pkg::PMPS_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 2'h1;
                end
            end
            default: begin
                next_r.state = pmps_pkg::PMPS_IDLE;
            end
        endcase
    end

    // State register; reset keeps the machine idle and marks the strap window.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r <= '0;
            r.in_reset <= 1'b1;
            r.strap <= pmps_pkg::STRAP_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Strobes are low only inside the strobe phase of their own direction.
    assign prog_read_strobe_low_o = !(r.state == pmps_pkg::PMPS_STROBE && !r.wr);
    assign prog_write_strobe_low_o = !(r.state == pmps_pkg::PMPS_STROBE && r.wr);
    // Enable held high in reset, dropped in standby, asserted otherwise and over every access.
    assign prog_chip_enable_low_o = reset_i || r.in_reset ||
        (standby_i && r.state == pmps_pkg::PMPS_IDLE);

    // Address and data pins; the write data holds through the hold phase.
    assign mem_addr_o = r.addr;
    assign mem_data_o = r.wdata;
    assign mem_data_oe_o = r.wr && r.state != pmps_pkg::PMPS_IDLE && !reset_i;
    // Upper pins drive outside reset; low pins are inputs in reset and the strap cycle.
    // Low pins are released in power down only if their strap bit is one.
    // One assignment covers the whole enable word so that it has a single driver.
    assign mem_addr_oe_o = {{(ADDR_W-2){!reset_i}},
        ((reset_i || r.in_reset) ? 2'h0 : (power_down_i ? ~r.strap : 2'h3))};
    assign mem_addr_pd_o = (reset_i || r.in_reset) ? 2'h3 : 2'h0;

    // Request handshake and status outputs.
    assign req_ready_o = r.state == pmps_pkg::PMPS_IDLE && !standby_i && !r.in_reset;
    assign rd_valid_o = r.rd_valid;
    assign rd_data_o = r.rdata;
    assign strap_o = r.strap;
    assign clk_sel_o = pmps_decode(r.strap);
endmodule // pmps_port

// [src/pmps_pkg.sv]
// Contract
// - While chip reset is held, the two lowest address pins are inputs carrying the clock-select strap with weak pull-downs on.
// - When chip reset is released, the strap is latched and those two pins go back to address outputs with pull-downs off.
// - The strap decodes as 00 for a 24 MHz clock, 11 for a 48 MHz clock, and 01 or 10 as reserved codes.
// - A low address pin whose strap bit latched as one is released whenever the chip is powered down.
// - A low address pin whose strap bit latched as zero is driven like every other address pin outside reset.
// - The active-low chip enable is asserted whenever the processor makes any external memory access.
// - The chip enable stays high for the whole time chip reset is held.
// - The chip enable stays asserted in normal operation and is released only in processor standby.
// - Addresses leave on a 17-bit output bus and data moves over an 8-bit two-way bus.
// - Separate active-low read and write strobes are driven, each only for its own kind of transfer.
package pmps_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 50;
    localparam int RESET_MIN_NS = 1000;
    // Least reset length in clock cycles, rounded up.
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    // Phase lengths of one access, in cycles.
    localparam logic [1:0] SETUP_CYC = 2'h1;
    localparam logic [1:0] STROBE_CYC = 2'h2;
    localparam logic [1:0] HOLD_CYC = 2'h1;
    localparam logic [1:0] STRAP_24MHZ = 2'h0;
    localparam logic [1:0] STRAP_48MHZ = 2'h3;
    localparam logic [1:0] STRAP_RESET = 2'h0;

    typedef enum logic [1:0] {
        PMPS_IDLE = 2'h0,
        PMPS_SETUP = 2'h1,
        PMPS_STROBE = 2'h3,
        PMPS_HOLD = 2'h2
    } pmps_state_t;

    typedef enum logic [1:0] {
        PMPS_CLK_24 = 2'h0,
        PMPS_CLK_48 = 2'h1,
        PMPS_CLK_RSVD = 2'h2
    } pmps_clk_t;
endpackage

// [verif/pmps_port_sva.sv]
`timescale 1ns/1ns
// Watches the strap, strobe and chip enable pins of the memory port.
module pmps_port_sva (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic power_down_i,
    input wire logic standby_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic req_ready_o,
    input wire logic rd_valid_o,
    input wire logic [1:0] strap_o,
    input wire logic [1:0] clk_sel_o,
    input wire logic [16:0] mem_addr_oe_o,
    input wire logic [1:0] mem_addr_pd_o,
    input wire logic prog_write_strobe_low_o,
    input wire logic prog_read_strobe_low_o,
    input wire logic prog_chip_enable_low_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // Accepted requests start the setup, strobe and release walk.
    sequence rd_take; req_valid_i && req_ready_o && !req_write_i; endsequence
    sequence wr_take; req_valid_i && req_ready_o && req_write_i; endsequence
    ce_in_reset_a: assert property (disable iff (1'b0) reset_i |-> prog_chip_enable_low_o)
        else $error("chip enable low in reset");
    pd_in_reset_a: assert property (disable iff (1'b0) reset_i |-> mem_addr_pd_o == 2'h3 && mem_addr_oe_o[1:0] == 2'h0)
        else $error("strap pins not inputs in reset");
    pd_release_a: assert property ($fell(reset_i) |-> ##2 mem_addr_pd_o == 2'h0)
        else $error("pull-downs still on");
    strap_hold_a: assert property (!$past(reset_i, 2) && !$past(reset_i) |-> $stable(strap_o))
        else $error("strap changed after latch");
    strap_dec_a: assert property (clk_sel_o == (strap_o == 2'h0 ? 2'h0 : strap_o == 2'h3 ? 2'h1 : 2'h2))
        else $error("clock select decode wrong");
    pwr_tri_a: assert property (power_down_i |-> (mem_addr_oe_o[1:0] & strap_o) == 2'h0)
        else $error("strap pin driven in power down");
    zero_drive_a: assert property (!$past(reset_i, 2) && !$past(reset_i) |-> (mem_addr_oe_o[1:0] | strap_o) == 2'h3)
        else $error("low address pin released");
    ce_on_a: assert property (!standby_i && !$past(reset_i, 2) && !$past(reset_i) |-> !prog_chip_enable_low_o)
        else $error("chip enable released");
    rd_walk_a: assert property (rd_take |=> prog_read_strobe_low_o ##1 (!prog_read_strobe_low_o && prog_write_strobe_low_o)[*2]
        ##1 prog_read_strobe_low_o && rd_valid_o) else $error("read walk wrong");
    wr_walk_a: assert property (wr_take |=> prog_write_strobe_low_o ##1 (!prog_write_strobe_low_o && prog_read_strobe_low_o)[*2]
        ##1 prog_write_strobe_low_o) else $error("write walk wrong");
endmodule // pmps_port_sva
bind pmps_port pmps_port_sva u_sva (.*);

// [verif/pmps_mem_model.sv]
`timescale 1ns/1ns
// Small static memory; only the low address nibble is decoded to keep it cheap.
module pmps_mem_model (
    input wire logic [16:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic ce_low_i,
    input wire logic rd_low_i,
    input wire logic wr_low_i,
    output logic [7:0] data_o
);
    logic [7:0] mem [0:15];
    // Data is taken as the write strobe rises, so it must stand until then.
    always @(posedge wr_low_i) if (!ce_low_i) mem[addr_i[3:0]] = data_i;
    // A released bus floats to its pull-up level.
    assign data_o = (!ce_low_i && !rd_low_i) ? mem[addr_i[3:0]] : 8'hff;
endmodule // pmps_mem_model

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, power_down_i = 1'b0, standby_i = 1'b0;
    logic req_valid_i = 1'b0, req_write_i = 1'b0, req_ready_o, rd_valid_o, mem_data_oe_o;
    logic [1:0] strap = 2'h3;
    logic [1:0] strap_o, clk_sel_o, mem_addr_pd_o, mem_addr_low_i;
    logic [16:0] req_addr_i = 17'h0, mem_addr_o, mem_addr_oe_o;
    logic [7:0] req_wdata_i = 8'h0, rd_data_o, mem_data_o, mem_data_i, bus_rd;
    logic prog_write_strobe_low_o, prog_read_strobe_low_o, prog_chip_enable_low_o;
    int n_errors = 0, check_count = 0, cycles = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    // Strap resistors outweigh the weak pull-downs whenever a pin is released.
    assign mem_addr_low_i = (mem_addr_oe_o[1:0] & mem_addr_o[1:0]) | (~mem_addr_oe_o[1:0] & strap);
    assign mem_data_i = mem_data_oe_o ? mem_data_o : bus_rd;
    pmps_port dut (.*);
    pmps_mem_model u_mem (.addr_i(mem_addr_o), .data_i(mem_data_o), .ce_low_i(prog_chip_enable_low_o),
        .rd_low_i(prog_read_strobe_low_o), .wr_low_i(prog_write_strobe_low_o), .data_o(bus_rd));
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Reset for the least legal length, then move the strap to show the latch holds.
    task automatic t_reset(input logic [1:0] s);
        reset_i = 1'b1;
        strap = s;
        repeat (pmps_pkg::RESET_MIN_CYC) @(posedge sys_clk_i);
        chk(mem_addr_pd_o, 2'h3);
        chk(prog_chip_enable_low_o, 1'b1);
        #2 reset_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #2 strap = ~s;
        @(posedge sys_clk_i);
        #2 chk(strap_o, s);
        chk(clk_sel_o, s == 2'h0 ? 2'h0 : s == 2'h3 ? 2'h1 : 2'h2);
        chk(mem_addr_pd_o, 2'h0);
    endtask
    task automatic t_power(input logic [16:0] e);
        power_down_i = 1'b1;
        @(posedge sys_clk_i);
        #2 chk(mem_addr_oe_o, e);
        power_down_i = 1'b0;
    endtask
    // Request held until taken; a read waits for its data pulse.
    task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        while (req_ready_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            #2 n++;
        end
        @(posedge sys_clk_i);
        #2 req_valid_i = 1'b0;
        do begin
            @(posedge sys_clk_i);
            #2 n++;
        end while (!wr && rd_valid_o !== 1'b1 && n < 30);
        if (!wr) chk(rd_data_o, d);
    endtask
    // Each scenario runs in turn; every strap code is latched once.
    initial begin
        for (int s = 0; s < 4; s++) begin
            t_reset(s[1:0]);
            t_power({15'h7fff, ~s[1:0]});
        end
        for (int i = 0; i < 4; i++) access(1'b1, {13'h1fff, i[3:0]}, 8'ha5 ^ i[7:0]);
        for (int i = 0; i < 4; i++) access(1'b0, {13'h1fff, i[3:0]}, 8'ha5 ^ i[7:0]);
        standby_i = 1'b1;
        @(posedge sys_clk_i);
        #2 chk(req_ready_o, 1'b0);
        chk(prog_chip_enable_low_o, 1'b1);
        standby_i = 1'b0;
        @(posedge sys_clk_i);
        #2 chk(prog_chip_enable_low_o, 1'b0);
        end_sim();
    end
    // Cuts a hung run short far beyond the few hundred cycles needed.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end
endmodule // testbench
